// [core/slcfg_pkg.sv]
`default_nettype none
package slcfg_pkg;
    // ==========================================================
    // Serial word layout
    localparam int WORD_W     = 32;
    localparam int SEL_W      = 3;
    localparam int NUM_LATCH  = 8;
    localparam int BIT_CNT_W  = 6;
    // ==========================================================
    // Latch 0 fields
    localparam int L0_MON_HI  = 30;
    localparam int L0_MON_LO  = 27;
    localparam int L0_INT_HI  = 26;
    localparam int L0_INT_LO  = 15;
    localparam int L0_FRH_HI  = 14;
    localparam int L0_FRH_LO  = 3;
    // ==========================================================
    // Latch 1 fields
    localparam int L1_FRL_HI  = 27;
    localparam int L1_FRL_LO  = 15;
    // ==========================================================
    // Latch 2 fields
    localparam int L2_CP_HI   = 27;
    localparam int L2_CP_LO   = 24;
    localparam int L2_HALF    = 21;
    localparam int L2_DBL     = 20;
    localparam int L2_RC_HI   = 19;
    localparam int L2_RC_LO   = 15;
    // ==========================================================
    // Widths and legal ranges
    localparam int INT_W      = 12;
    localparam int FRAC_W     = 25;
    localparam int FRH_W      = 12;
    localparam int FRL_W      = 13;
    localparam int RC_W       = 5;
    localparam int CP_W       = 4;
    localparam int MON_W      = 4;
    localparam logic [11:0] INT_MIN = 12'h017;
    localparam logic [11:0] INT_MAX = 12'hfff;
    // Monitor select codes
    localparam logic [3:0] MON_LOW   = 4'h0;
    localparam logic [3:0] MON_HIGH  = 4'h1;
    localparam logic [3:0] MON_INTOK = 4'h2;
    localparam logic [3:0] MON_DBL   = 4'h3;
    localparam logic [3:0] MON_HALF  = 4'h4;
    localparam logic [3:0] MON_EN    = 4'h5;
    // Host serial clock divider: half period in clk cycles
    localparam int SCK_HALF   = 8;
    localparam int SCK_CNT_W  = 4;
endpackage
`default_nettype wire

// [core/slcfg_if.sv]
`default_nettype none
interface slcfg_if;
    logic serialClk;
    logic serialData;
    logic load_strobe;
    logic chipEnable;
    logic monitor_output;
    logic cpOut;
    logic cpOutEn;
    modport dev  (input serialClk, input serialData, input load_strobe, input chipEnable,
                  output monitor_output, output cpOut, output cpOutEn);
    modport host (output serialClk, output serialData, output load_strobe,
                  output chipEnable, input monitor_output, input cpOut, input cpOutEn);
endinterface
`default_nettype wire

// [core/slcfg_device.sv]
// Overview of operation
// - Shift one bit per serial clock rise
// - Host sends MSB first, select bits last
// - Load strobe rise copies word to latch
// - Word bits 2..0 pick latch
// - Buffered settings wait for latch 0 write
// - New frequency applies on latch 0 write
// - Host writes latch 1 before latch 0
// - Fraction is 12 high plus 13 low bits
// - Integer divider legal range 23..4095
// - Reference divider ratio 1..32
// - Fixed modulus two to the 25
// - Detector rate uses doubler, halving, ratio
// - Monitor output chosen by 4-bit select
// - Chip enable low powers down, pump off
`default_nettype none
module slcfg_device (
    // Link
    slcfg_if.dev                         link,
    // Active settings
    output logic [slcfg_pkg::INT_W-1:0]  intValue,
    output logic [slcfg_pkg::FRAC_W-1:0] fracValue,
    output logic [slcfg_pkg::RC_W-1:0]   refCountCode,
    output logic [5:0]                   refRatio,
    output logic                         refDoubler,
    output logic                         reference_halving_bit,
    output logic [slcfg_pkg::CP_W-1:0]   cpCurrent,
    output logic [slcfg_pkg::MON_W-1:0]  monitorSelect,
    output logic                         intInRange,
    output logic                         powerDown,
    output logic [slcfg_pkg::WORD_W-1:0] latchView [slcfg_pkg::NUM_LATCH]
);
    // ==========================================================
    // Serial capture, on the link clock
    logic [slcfg_pkg::WORD_W-1:0] shift_reg;
    logic [slcfg_pkg::WORD_W-1:0] latch_reg [slcfg_pkg::NUM_LATCH];

    always_ff @(posedge link.serialClk) begin
        shift_reg <= {shift_reg[slcfg_pkg::WORD_W-2:0], link.serialData};
    end

    wire [slcfg_pkg::SEL_W-1:0] latchSel = shift_reg[slcfg_pkg::SEL_W-1:0];
    wire                        loadL0   = (latchSel == 3'h0);

    // Latches hold until selected; nothing resets them since the part has no reset pin
    always_ff @(posedge link.load_strobe) begin
        latch_reg[latchSel] <= shift_reg;
    end

    // ==========================================================
    // Double buffer: staged latch 1/2 fields move forward on a latch 0 load
    logic [slcfg_pkg::FRL_W-1:0] fracLo_reg;
    logic [slcfg_pkg::RC_W-1:0]  refCode_reg;
    logic                        dbl_reg;
    logic                        half_reg;
    logic [slcfg_pkg::CP_W-1:0]  cp_reg;

    always_ff @(posedge link.load_strobe) begin
        if (loadL0) begin
            fracLo_reg  <= latch_reg[1][slcfg_pkg::L1_FRL_HI:slcfg_pkg::L1_FRL_LO];
            refCode_reg <= latch_reg[2][slcfg_pkg::L2_RC_HI:slcfg_pkg::L2_RC_LO];
            dbl_reg     <= latch_reg[2][slcfg_pkg::L2_DBL];
            half_reg    <= latch_reg[2][slcfg_pkg::L2_HALF];
            cp_reg      <= latch_reg[2][slcfg_pkg::L2_CP_HI:slcfg_pkg::L2_CP_LO];
        end
    end

    // ==========================================================
    // Settings as seen by the synthesizer core
    always_comb begin
        intValue              = latch_reg[0][slcfg_pkg::L0_INT_HI:slcfg_pkg::L0_INT_LO];
        fracValue             = {latch_reg[0][slcfg_pkg::L0_FRH_HI:slcfg_pkg::L0_FRH_LO],
                                 fracLo_reg};
        refCountCode          = refCode_reg;
        // Code 0 means divide by 32
        refRatio              = (refCode_reg == 5'h00) ? 6'h20 : {1'b0, refCode_reg};
        refDoubler            = dbl_reg;
        reference_halving_bit = half_reg;
        cpCurrent             = cp_reg;
        monitorSelect         = latch_reg[0][slcfg_pkg::L0_MON_HI:slcfg_pkg::L0_MON_LO];
        intInRange            = (intValue >= slcfg_pkg::INT_MIN);
        powerDown             = ~link.chipEnable;
        for (int i = 0; i < slcfg_pkg::NUM_LATCH; i++) begin
            latchView[i] = latch_reg[i];
        end
    end

    // ==========================================================
    // Monitor mux and charge pump enable
    logic monMux;
    always_comb begin
        unique case (monitorSelect)
            slcfg_pkg::MON_LOW:   monMux = 1'b0;
            slcfg_pkg::MON_HIGH:  monMux = 1'b1;
            slcfg_pkg::MON_INTOK: monMux = intInRange;
            slcfg_pkg::MON_DBL:   monMux = refDoubler;
            slcfg_pkg::MON_HALF:  monMux = reference_halving_bit;
            slcfg_pkg::MON_EN:    monMux = link.chipEnable;
            default:              monMux = 1'b0;
        endcase
    end

    assign link.monitor_output = monMux;
    assign link.cpOut          = 1'b0;
    assign link.cpOutEn        = link.chipEnable;
endmodule
`default_nettype wire

// [core/slcfg_host.sv]
// The APB interface to the registers and the address map are this design's own decisions.
`default_nettype none
module slcfg_host (
    // System
    input  wire logic                         clk,
    input  wire logic                         rst,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [3:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Link
    slcfg_if.host                             link
);
    // ==========================================================
    // Registers: 0x0 word, 0x4 control (bit0 chip enable), 0x8 status (bit0 busy), 0xc monitor (bit0 synced monitor)
    localparam logic [3:0] A_WORD = 4'h0;
    localparam logic [3:0] A_CTRL = 4'h4;
    localparam logic [3:0] A_STAT = 4'h8;
    localparam logic [3:0] A_MON  = 4'hc;

    typedef enum logic [3:0] {
        IDLE = 4'b0001, SHIFT = 4'b0010, LOAD = 4'b0100, DONE = 4'b1000
    } slcfg_state_t;

    slcfg_state_t state_reg;
    logic [31:0]  word_reg;
    logic         ce_reg;
    logic [5:0]   bits_reg;
    logic [3:0]   div_reg;
    logic         sck_reg;
    logic         sdo_reg;
    logic         le_reg;
    logic         mon1_reg;
    logic         mon2_reg;

    wire access = psel & penable;
    wire busy   = (state_reg != IDLE);
    wire wrWord = access & pwrite & (paddr == A_WORD) & ~busy;
    wire tick   = (div_reg == 4'(slcfg_pkg::SCK_HALF - 1));
    wire mapped = (paddr == A_WORD) | (paddr == A_CTRL) | (paddr == A_STAT) | (paddr == A_MON);
    wire [31:0] rdMux = (paddr == A_WORD) ? word_reg :
                        (paddr == A_CTRL) ? {31'h0, ce_reg} :
                        (paddr == A_STAT) ? {31'h0, busy} :
                        (paddr == A_MON)  ? {31'h0, mon2_reg} : 32'h0;

    // ==========================================================
    // APB: zero wait, word write refused while busy
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | (pwrite & (paddr == A_WORD) & busy));
    assign prdata  = rdMux;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon1_reg <= 1'b0;
            mon2_reg <= 1'b0;
        end else begin
            mon1_reg <= link.monitor_output;
            mon2_reg <= mon1_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) ce_reg <= 1'b0;
        else if (access & pwrite & (paddr == A_CTRL)) ce_reg <= pwdata[0];
    end

    // ==========================================================
    // Serial engine: MSB first, data changes while clock is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= IDLE;
            word_reg  <= 32'h0;
            bits_reg  <= 6'h0;
            div_reg   <= 4'h0;
            sck_reg   <= 1'b0;
            sdo_reg   <= 1'b0;
            le_reg    <= 1'b0;
        end else begin
            div_reg <= (busy & ~tick) ? div_reg + 4'h1 : 4'h0;
            unique case (state_reg)
                IDLE: if (wrWord) begin
                    word_reg  <= pwdata;
                    sdo_reg   <= pwdata[31];
                    bits_reg  <= 6'h0;
                    state_reg <= SHIFT;
                end
                SHIFT: if (tick) begin
                    sck_reg <= ~sck_reg;
                    if (sck_reg) begin
                        if (bits_reg == 6'd31) state_reg <= LOAD;
                        else begin
                            bits_reg <= bits_reg + 6'h1;
                            sdo_reg  <= word_reg[5'(30 - bits_reg)];
                        end
                    end
                end
                LOAD: if (tick) begin
                    le_reg <= ~le_reg;
                    if (le_reg) state_reg <= DONE;
                end
                DONE: if (tick) state_reg <= IDLE;
                default: state_reg <= IDLE;
            endcase
        end
    end

    assign link.serialClk   = sck_reg;
    assign link.serialData  = sdo_reg;
    assign link.load_strobe = le_reg;
    assign link.chipEnable  = ce_reg;
endmodule
`default_nettype wire

// [dv/slcfg_link_asserts.sv]
`default_nettype none
module slcfg_link_asserts (
    // System
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic load_strobe,
    input wire logic chipEnable,
    input wire logic monitor_output,
    input wire logic cpOut,
    input wire logic cpOutEn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Rises per frame; cleared while the strobe is high
    logic [5:0] riseCnt_reg;
    logic       sckPrev_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            riseCnt_reg <= 6'h00;
            sckPrev_reg <= 1'b0;
        end else begin
            sckPrev_reg <= serialClk;
            if (load_strobe) begin
                riseCnt_reg <= 6'h00;
            end else if (serialClk && !sckPrev_reg) begin
                riseCnt_reg <= riseCnt_reg + 6'h01;
            end
        end
    end
    // ==========================================================
    // Properties
    property p_pumpOff; !chipEnable |-> !cpOutEn && !cpOut; endproperty
    property p_sckHigh; $rose(serialClk) |-> serialClk[*8] ##1 !serialClk; endproperty
    property p_sckLow; $fell(serialClk) |-> !serialClk[*8]; endproperty
    property p_dataHeld; serialClk |-> $stable(serialData); endproperty
    property p_wordLen; $rose(load_strobe) |-> riseCnt_reg == 6'h20; endproperty
    property p_strobeWidth; $rose(load_strobe) |-> load_strobe[*8] ##1 !load_strobe; endproperty
    property p_strobeNoSck; load_strobe |-> !serialClk; endproperty
    property p_strobeGap; $fell(load_strobe) |-> !serialClk[*8]; endproperty
    a_pumpOff: assert property (p_pumpOff) else $error("pump active while disabled");
    a_sckHigh: assert property (p_sckHigh) else $error("serial clock high time wrong");
    a_sckLow: assert property (p_sckLow) else $error("serial clock low time wrong");
    a_dataHeld: assert property (p_dataHeld) else $error("data moved at clock high");
    a_wordLen: assert property (p_wordLen) else $error("frame not 32 clocks");
    a_strobeWidth: assert property (p_strobeWidth) else $error("strobe width wrong");
    a_strobeNoSck: assert property (p_strobeNoSck) else $error("clock during strobe");
    a_strobeGap: assert property (p_strobeGap) else $error("clock too soon after strobe");
    c_load: cover property ($rose(load_strobe));
    c_enable: cover property ($rose(chipEnable));
    c_monitor: cover property ($rose(monitor_output));
endmodule
`default_nettype wire

// [dv/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [3:0]  paddr = 4'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        err;
    logic [31:0] shadow [8];
    int          num_errors = 0;
    int          comparisons = 0;
    logic [11:0] intValue;
    logic [24:0] fracValue;
    logic [4:0]  refCountCode;
    logic [5:0]  refRatio;
    logic        refDoubler;
    logic        reference_halving_bit;
    logic [3:0]  cpCurrent;
    logic [3:0]  monitorSelect;
    logic        intInRange;
    logic        powerDown;
    logic [31:0] latchView [8];
    slcfg_if linkBus ();
    slcfg_host slcfg_host_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(linkBus));
    slcfg_device slcfg_device_i (.link(linkBus), .intValue(intValue), .fracValue(fracValue),
        .refCountCode(refCountCode), .refRatio(refRatio), .refDoubler(refDoubler),
        .reference_halving_bit(reference_halving_bit), .cpCurrent(cpCurrent),
        .monitorSelect(monitorSelect), .intInRange(intInRange), .powerDown(powerDown),
        .latchView(latchView));
    slcfg_link_asserts slcfg_link_asserts_i (.clk(clk), .rst(rst),
        .serialClk(linkBus.serialClk), .serialData(linkBus.serialData),
        .load_strobe(linkBus.load_strobe), .chipEnable(linkBus.chipEnable),
        .monitor_output(linkBus.monitor_output), .cpOut(linkBus.cpOut),
        .cpOutEn(linkBus.cpOutEn));
    always #2.5 clk = ~clk;
    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Polls busy; the next word must not start earlier
    task automatic waitIdle();
        rd = 32'h1;
        for (int n = 0; n < 2000 && rd[0] !== 1'b0; n++) begin
            apb(1'b0, 4'h8, 32'h0);
        end
        // A poll limit that runs out lands here as a mismatch
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask
    task automatic send(input logic [31:0] word);
        shadow[word[2:0]] = word;
        apb(1'b1, 4'h0, word);
        waitIdle();
    endtask
    function automatic logic [31:0] w0(input logic [3:0] m, input logic [11:0] i,
                                       input logic [11:0] f);
        return {1'b0, m, i, f, 3'h0};
    endfunction
    function automatic logic [31:0] w2(input logic [3:0] cp, input logic h, input logic d,
                                       input logic [4:0] rc);
        return {4'h0, cp, 2'h0, h, d, rc, 12'h000, 3'h2};
    endfunction
    task automatic act(input logic [24:0] fr, input logic [4:0] rc, input logic [5:0] ratio,
                       input logic [1:0] dh, input logic [3:0] cp, input logic [11:0] iv);
        chk("fracValue", {7'h0, fr}, {7'h0, fracValue});
        chk("refCountCode", {27'h0, rc}, {27'h0, refCountCode});
        chk("refRatio", {26'h0, ratio}, {26'h0, refRatio});
        chk("doublerHalving", {30'h0, dh}, {30'h0, refDoubler, reference_halving_bit});
        chk("cpCurrent", {28'h0, cp}, {28'h0, cpCurrent});
        chk("intValue", {20'h0, iv}, {20'h0, intValue});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk("pumpEnable", 32'h0, {31'h0, linkBus.cpOutEn});
        chk("powerDown", 32'h1, {31'h0, powerDown});
        apb(1'b1, 4'h4, 32'h1);
        apb(1'b0, 4'h4, 32'h0);
        chk("ctrlReg", 32'h1, rd);
        chk("pumpEnable", 32'h1, {31'h0, linkBus.cpOutEn});
        chk("powerDown", 32'h0, {31'h0, powerDown});
        apb(1'b0, 4'h2, 32'h0);
        chk("unmappedErr", 32'h1, {31'h0, err});
        chk("unmappedData", 32'h0, rd);
        $display("test enable done");
        send({4'h0, 13'h1abc, 12'h000, 3'h1});
        send(w2(4'ha, 1'b1, 1'b1, 5'h00));
        send(w0(4'h5, 12'h017, 12'hfed));
        act({12'hfed, 13'h1abc}, 5'h00, 6'h20, 2'h3, 4'ha, 12'h017);
        chk("intInRange", 32'h1, {31'h0, intInRange});
        chk("monitor", 32'h1, {31'h0, linkBus.monitor_output});
        apb(1'b0, 4'hc, 32'h0);
        chk("monitorReg", 32'h1, {31'h0, rd[0]});
        apb(1'b0, 4'h0, 32'h0);
        chk("wordReg", w0(4'h5, 12'h017, 12'hfed), rd);
        $display("test first load done");
        send({4'h0, 13'h0123, 12'h000, 3'h1});
        send(w2(4'h3, 1'b0, 1'b0, 5'h01));
        act({12'hfed, 13'h1abc}, 5'h00, 6'h20, 2'h3, 4'ha, 12'h017);
        // Second word lands while busy and must be dropped
        shadow[3] = 32'h5a5a_a5a3;
        apb(1'b1, 4'h0, shadow[3]);
        chk("acceptErr", 32'h0, {31'h0, err});
        apb(1'b1, 4'h0, 32'hffff_fffb);
        chk("refused", 32'h1, {31'h0, err});
        waitIdle();
        for (int k = 4; k < 8; k++) send({24'(k) * 24'h010101, 5'h15, 3'(k)});
        for (int n = 0; n < 8; n++) chk("latchView", shadow[n], latchView[n]);
        $display("test latches done");
        send(w0(4'h0, 12'h016, 12'h001));
        act({12'h001, 13'h0123}, 5'h01, 6'h01, 2'h0, 4'h3, 12'h016);
        chk("intInRange", 32'h0, {31'h0, intInRange});
        chk("monitorSelect", 32'h0, {28'h0, monitorSelect});
        apb(1'b0, 4'hc, 32'h0);
        chk("monitorReg", 32'h0, {31'h0, rd[0]});
        // Codes 1..4: high, integer in range, doubler (0), halving (0)
        for (int m = 1; m < 5; m++) begin
            send(w0(4'(m), 12'h017, 12'h001));
            chk("monitor", (m < 3) ? 32'h1 : 32'h0, {31'h0, linkBus.monitor_output});
        end
        apb(1'b1, 4'h4, 32'h0);
        apb(1'b0, 4'h4, 32'h0);
        chk("ctrlReg", 32'h0, rd);
        chk("pumpEnable", 32'h0, {31'h0, linkBus.cpOutEn});
        chk("powerDown", 32'h1, {31'h0, powerDown});
        $display("test second load done");
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        $display("test watchdog expired");
        report_and_stop();
    end
endmodule
`default_nettype wire
